// ===== hdl/sepw_params.svh
`ifndef SEPW_PARAMS_SVH
`define SEPW_PARAMS_SVH

`define SEPW_CLK_NS 25
// Arbitrary device type code
`define SEPW_DEV_TYPE 4'h6
`define SEPW_MEM_BYTES 8192
`define SEPW_ADDR_BYTES 2
`define SEPW_PAGE_BITS 5
`define SEPW_PAGE_BYTES 32
`define SEPW_FILT_NS 50
`define SEPW_FILT_CYC ((`SEPW_FILT_NS + `SEPW_CLK_NS - 1) / `SEPW_CLK_NS)
`define SEPW_WC_CYCLES 400
`define SEPW_POR_CYC 4'hf
`define SEPW_ACK_BIT 4'h8
`define SEPW_END_BIT 4'h9
`define SEPW_SCL_HALF_NS 2000
`define SEPW_SCL_HALF (`SEPW_SCL_HALF_NS / `SEPW_CLK_NS)
// Controller wait after scl falls before pulling sda; longer than the device's sync and filter delay
`define SEPW_SDA_HOLD 16'h0008

`endif

// ===== hdl/sepw_pkg.sv
package sepw_pkg;

    typedef enum logic [2:0] {
        SEPW_S_IDLE = 3'h0,
        SEPW_S_DEV = 3'h1,
        SEPW_S_ADR = 3'h2,
        SEPW_S_WR = 3'h3,
        SEPW_S_RD = 3'h4,
        SEPW_S_IGN = 3'h5
    } sepw_dev_state_t;

    typedef enum logic [1:0] {
        SEPW_C_IDLE = 2'h0,
        SEPW_C_START = 2'h1,
        SEPW_C_STOP = 2'h2,
        SEPW_C_BYTE = 2'h3
    } sepw_ctl_state_t;

    typedef enum logic [1:0] {
        SEPW_OP_START = 2'h0,
        SEPW_OP_STOP = 2'h1,
        SEPW_OP_WRITE = 2'h2,
        SEPW_OP_READ = 2'h3
    } sepw_op_t;

endpackage

// ===== hdl/sepw_link_if.sv
`timescale 1ns/1ps
interface sepw_link_if;
    logic scl;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic ctl_sda_o;
    logic ctl_sda_oe;
    logic sda;

    // Open-drain wire with pull-up: low while any enabled driver drives low
    assign sda = ~((dev_sda_oe & ~dev_sda_o) | (ctl_sda_oe & ~ctl_sda_o));

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport ctl (output scl, input sda, output ctl_sda_o, output ctl_sda_oe);
endinterface

// ===== hdl/sepw_device.sv
`timescale 1ns/1ps
`include "sepw_params.svh"
// Contract
// - Accept 1 to 32 bytes, program together
// - Second data byte switches to page write
// - Increment low five bits, wrap in page
// - Stop after data starts timed programming
// - Controller polls with write-direction address word
// - No ack while programming, ack after
// - Reads start like writes, direction high
// - Counter holds last accessed address plus one
// - Read word acked, byte sent msb first
// - Master no-ack then stop ends read
// - Read counter wraps to zero at end
// - Write counter wraps within same page
// - Counter undefined until random read sets it; here reset loads it with zero
// - Random read: dummy write then repeated start
// - Master ack gives next byte
// - Sequential read wraps to zero, continues
// - Filter pulses shorter than 50 ns
// - Power-on guard blocks spurious programming
// - Controller keeps lines static during power switching
// - Type code, select bits, direction bit
// - Receiver acks low on ninth clock
// - One or two memory address bytes
module sepw_device #(
    parameter int MEM_BYTES = `SEPW_MEM_BYTES,
    parameter int ADDR_BYTES = `SEPW_ADDR_BYTES,
    parameter int WC_CYCLES = `SEPW_WC_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] dev_sel,
    sepw_link_if.dev link,
    output logic busy
);
    import sepw_pkg::*;

    localparam int AW = $clog2(MEM_BYTES);
    localparam int PB = `SEPW_PAGE_BITS;
    localparam int WCW = $clog2(WC_CYCLES + 1);
    localparam int FCW = 2;
    localparam int SELB = (ADDR_BYTES == 1 && AW > 8) ? AW - 8 : 0;
    localparam logic [2:0] SEL_MASK = 3'(3'h7 << SELB);

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic [1:0] filt;
        logic [1:0] prev;
        logic [1:0][FCW-1:0] fcnt;
        logic por_ok;
        logic [3:0] por_cnt;
        sepw_dev_state_t state;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic mack;
        logic drive;
        logic [2:0] dsel_hi;
        logic [7:0] ahi;
        logic abyte;
        logic [AW-1:0] addr;
        logic [`SEPW_PAGE_BYTES-1:0] pvalid;
        logic [AW-PB-1:0] ppage;
        logic busy;
        logic [WCW-1:0] wc;
        logic [PB-1:0] pidx;
    } sepw_dev_reg_t;

    sepw_dev_reg_t st;
    sepw_dev_reg_t next_st;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [`SEPW_PAGE_BYTES];
    logic [7:0] rdata;
    logic pb_we;
    logic [PB-1:0] pb_idx;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic sel_hit;
    logic [7:0] addr_hi;

    assign rdata = mem[st.addr];
    assign scl_rise = st.filt[1] & ~st.prev[1];
    assign scl_fall = ~st.filt[1] & st.prev[1];
    assign start_cond = st.filt[1] & st.prev[1] & st.prev[0] & ~st.filt[0];
    assign stop_cond = st.filt[1] & st.prev[1] & ~st.prev[0] & st.filt[0];
    assign sel_hit = (st.shreg[7:4] == `SEPW_DEV_TYPE) && (((st.shreg[3:1] ^ st.sel_s2) & SEL_MASK) == 3'h0);
    assign addr_hi = (ADDR_BYTES == 2) ? st.ahi : {5'h00, st.dsel_hi};

    always_comb begin
        next_st = st;
        pb_we = 1'b0;
        pb_idx = st.addr[PB-1:0];
        next_st.sync1 = {link.scl, link.sda};
        next_st.sync2 = st.sync1;
        next_st.sel_s1 = dev_sel;
        next_st.sel_s2 = st.sel_s1;
        next_st.prev = st.filt;
        // A level must hold for the suppression width before it is believed
        for (int i = 0; i < 2; i++) begin
            if (st.sync2[i] == st.filt[i]) begin
                next_st.fcnt[i] = '0;
            end else if (st.fcnt[i] == FCW'(`SEPW_FILT_CYC - 1)) begin
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = '0;
            end else begin
                next_st.fcnt[i] = st.fcnt[i] + 1'b1;
            end
        end
        // Bus is not trusted until both lines sit high for a while after reset
        if (!st.por_ok) begin
            next_st.por_cnt = (st.filt == 2'h3) ? st.por_cnt + 1'b1 : 4'h0;
            if (st.por_cnt == `SEPW_POR_CYC) begin
                next_st.por_ok = 1'b1;
            end
        end
        if (st.busy) begin
            next_st.pidx = st.pidx + 1'b1;
            if (st.wc == '0) begin
                next_st.busy = 1'b0;
                next_st.pvalid = '0;
            end else begin
                next_st.wc = st.wc - 1'b1;
            end
        end
        if (!st.por_ok) begin
            next_st.state = SEPW_S_IDLE;
        end else if (start_cond) begin
            next_st.state = SEPW_S_DEV;
            next_st.cnt = 4'h0;
            next_st.drive = 1'b0;
        end else if (stop_cond) begin
            if (st.state == SEPW_S_WR && st.pvalid != '0) begin
                next_st.busy = 1'b1;
                next_st.wc = WCW'(WC_CYCLES);
                next_st.pidx = '0;
            end
            next_st.state = SEPW_S_IDLE;
            next_st.drive = 1'b0;
        end else if (st.state != SEPW_S_IDLE && st.state != SEPW_S_IGN) begin
            if (scl_rise) begin
                if (st.cnt < `SEPW_ACK_BIT) begin
                    next_st.shreg = {st.shreg[6:0], st.filt[0]};
                end else begin
                    next_st.mack = st.filt[0];
                end
                next_st.cnt = st.cnt + 1'b1;
            end else if (scl_fall) begin
                case (st.cnt)
                    `SEPW_ACK_BIT: begin
                        case (st.state)
                            SEPW_S_DEV: begin
                                if (!sel_hit || st.busy) begin
                                    next_st.state = SEPW_S_IGN;
                                end else begin
                                    next_st.drive = 1'b1;
                                    next_st.dsel_hi = st.shreg[3:1];
                                    next_st.abyte = 1'b0;
                                    if (!st.shreg[0]) begin
                                        next_st.state = SEPW_S_ADR;
                                        next_st.pvalid = '0;
                                    end
                                end
                            end
                            SEPW_S_ADR: begin
                                next_st.drive = 1'b1;
                                if (ADDR_BYTES == 2 && !st.abyte) begin
                                    next_st.ahi = st.shreg;
                                    next_st.abyte = 1'b1;
                                end else begin
                                    next_st.addr = AW'({addr_hi, st.shreg});
                                    next_st.ppage = next_st.addr[AW-1:PB];
                                    next_st.state = SEPW_S_WR;
                                end
                            end
                            SEPW_S_WR: begin
                                next_st.drive = 1'b1;
                                pb_we = 1'b1;
                                next_st.pvalid[st.addr[PB-1:0]] = 1'b1;
                                next_st.addr[PB-1:0] = st.addr[PB-1:0] + 1'b1;
                            end
                            SEPW_S_RD: begin
                                next_st.drive = 1'b0;
                            end
                            default: begin
                                next_st.drive = 1'b0;
                            end
                        endcase
                    end
                    `SEPW_END_BIT: begin
                        next_st.drive = 1'b0;
                        next_st.cnt = 4'h0;
                        if (st.state == SEPW_S_DEV || (st.state == SEPW_S_RD && !st.mack)) begin
                            next_st.state = SEPW_S_RD;
                            next_st.shreg = rdata;
                            next_st.drive = ~rdata[7];
                            next_st.addr = st.addr + 1'b1;
                        end else if (st.state == SEPW_S_RD) begin
                            next_st.state = SEPW_S_IGN;
                        end
                    end
                    default: begin
                        if (st.state == SEPW_S_RD) begin
                            next_st.drive = ~st.shreg[7];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{sync1: 2'h3, sync2: 2'h3, filt: 2'h3, prev: 2'h3, state: SEPW_S_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (pb_we) begin
            pbuf[pb_idx] <= st.shreg;
        end
        if (st.busy && st.pvalid[st.pidx]) begin
            mem[{st.ppage, st.pidx}] <= pbuf[st.pidx];
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = st.drive;
    assign busy = st.busy;
endmodule

// ===== hdl/sepw_ctl.sv
`timescale 1ns/1ps
`include "sepw_params.svh"
module sepw_ctl #(
    parameter int SCL_HALF = `SEPW_SCL_HALF
) (
    input wire logic clk,
    input wire logic reset_n,
    sepw_link_if.ctl link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sepw_pkg::sepw_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    import sepw_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        sepw_ctl_state_t state;
        logic [1:0] ph;
        logic [15:0] tmr;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic rd;
        logic nack;
        logic scl;
        logic sda_lo;
        logic cmd_ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_ack;
    } sepw_ctl_reg_t;

    sepw_ctl_reg_t st;
    sepw_ctl_reg_t next_st;
    logic tick;

    assign tick = (st.tmr == 16'(SCL_HALF - 1));

    always_comb begin
        next_st = st;
        next_st.sync1 = link.sda;
        next_st.sync2 = st.sync1;
        next_st.rsp_valid = 1'b0;
        next_st.tmr = (tick || st.state == SEPW_C_IDLE) ? 16'h0000 : st.tmr + 1'b1;
        case (st.state)
            SEPW_C_IDLE: begin
                next_st.cmd_ready = 1'b1;
                if (cmd_valid && st.cmd_ready) begin
                    next_st.cmd_ready = 1'b0;
                    next_st.ph = 2'h0;
                    next_st.bitn = 4'h0;
                    next_st.rd = (cmd_op == SEPW_OP_READ);
                    next_st.nack = cmd_nack;
                    next_st.shreg = (cmd_op == SEPW_OP_READ) ? 8'hff : cmd_data;
                    case (cmd_op)
                        SEPW_OP_START: begin
                            next_st.state = SEPW_C_START;
                            next_st.sda_lo = 1'b0;
                        end
                        SEPW_OP_STOP: begin
                            next_st.state = SEPW_C_STOP;
                            next_st.sda_lo = 1'b1;
                        end
                        default: begin
                            next_st.state = SEPW_C_BYTE;
                            next_st.ph = 2'h2;
                        end
                    endcase
                end
            end
            SEPW_C_START: begin
                if (tick) begin
                    next_st.ph = st.ph + 1'b1;
                    case (st.ph)
                        2'h0: next_st.scl = 1'b1;
                        2'h1: next_st.sda_lo = 1'b1;
                        default: begin
                            next_st.scl = 1'b0;
                            next_st.state = SEPW_C_IDLE;
                        end
                    endcase
                end
            end
            SEPW_C_STOP: begin
                if (tick) begin
                    next_st.ph = st.ph + 1'b1;
                    case (st.ph)
                        2'h0: next_st.scl = 1'b1;
                        2'h1: next_st.sda_lo = 1'b0;
                        default: next_st.state = SEPW_C_IDLE;
                    endcase
                end
            end
            SEPW_C_BYTE: begin
                case (st.ph)
                    2'h2: begin
                        // Pull low only once the device has seen scl fall and let go of the line
                        if (st.tmr == `SEPW_SDA_HOLD) begin
                            next_st.tmr = 16'h0000;
                            next_st.ph = 2'h0;
                            if (st.bitn < `SEPW_ACK_BIT) begin
                                next_st.sda_lo = ~st.rd & ~st.shreg[7];
                            end else if (st.bitn == `SEPW_ACK_BIT) begin
                                next_st.sda_lo = st.rd & ~st.nack;
                            end else begin
                                next_st.state = SEPW_C_IDLE;
                            end
                        end
                    end
                    2'h0: begin
                        if (tick) begin
                            next_st.scl = 1'b1;
                            next_st.ph = 2'h1;
                        end
                    end
                    default: begin
                        if (tick) begin
                            // Release with the falling clock so the device may drive its next bit
                            next_st.scl = 1'b0;
                            next_st.sda_lo = 1'b0;
                            next_st.ph = 2'h2;
                            next_st.bitn = st.bitn + 1'b1;
                            if (st.bitn < `SEPW_ACK_BIT) begin
                                next_st.shreg = {st.shreg[6:0], st.sync2};
                            end else begin
                                next_st.rsp_valid = 1'b1;
                                next_st.rsp_data = st.shreg;
                                next_st.rsp_ack = ~st.sync2;
                            end
                        end
                    end
                endcase
            end
            default: next_st.state = SEPW_C_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{sync1: 1'b1, sync2: 1'b1, state: SEPW_C_IDLE, scl: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.scl = st.scl;
    assign link.ctl_sda_o = 1'b0;
    assign link.ctl_sda_oe = st.sda_lo;
    assign cmd_ready = st.cmd_ready;
    assign rsp_valid = st.rsp_valid;
    assign rsp_data = st.rsp_data;
    assign rsp_ack = st.rsp_ack;
endmodule

// ===== tb/sepw_link_props.sv
`timescale 1ns/1ps
module sepw_link_props #(
    parameter int WC_CYCLES = 400
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic ctl_sda_oe,
    input wire logic busy
);
    logic [15:0] busy_cnt;
    logic [5:0] stop_age;
    logic sda_q;

    // Cycles since the last raw stop on the wire, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 16'h0000;
            stop_age <= 6'h3f;
            sda_q <= 1'b1;
        end else begin
            sda_q <= sda;
            busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
            if (scl && sda && !sda_q) begin
                stop_age <= 6'h00;
            end else if (stop_age != 6'h3f) begin
                stop_age <= stop_age + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_busy_hold;
        busy [*8];
    endsequence

    sequence s_guard_quiet;
        !dev_sda_oe [*8];
    endsequence

    chk_busy_length: assert property ($fell(busy) |-> busy_cnt == 16'(WC_CYCLES + 1))
        else $error("programming time differs from the set cycle count");
    chk_busy_bound: assert property (busy |-> busy_cnt <= 16'(WC_CYCLES + 1))
        else $error("programming runs past its cycle count");
    chk_busy_hold: assert property ($rose(busy) |-> s_busy_hold)
        else $error("programming cycle cut short");
    chk_busy_after_stop: assert property ($rose(busy) |-> stop_age < 6'h10)
        else $error("programming started without a stop");
    chk_busy_no_ack: assert property (busy |-> !dev_sda_oe)
        else $error("device drives the line while programming");
    chk_oe_scl_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device changes data while clock is high");
    chk_one_driver: assert property (!(dev_sda_oe && ctl_sda_oe))
        else $error("both ends drive the data line");
    chk_guard_quiet: assert property ($rose(reset_n) |-> s_guard_quiet)
        else $error("device answers during power-on guard");
    chk_idle_release: assert property ($rose(reset_n) |-> scl && sda && !busy)
        else $error("lines not idle at reset release");
endmodule

// ===== tb/serial_eeprom_page_write_read_tb.sv
`timescale 1ns/1ps
`include "sepw_params.svh"
module serial_eeprom_page_write_read_tb;
    import sepw_pkg::*;
    localparam int WC = 1000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    sepw_op_t cmd_op = SEPW_OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nack = 1'b0;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ack;
    logic busy;
    logic [2:0] dev_sel = 3'h5;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] q[$];

    sepw_link_if link();
    sepw_device #(.MEM_BYTES(8192), .ADDR_BYTES(2), .WC_CYCLES(WC)) sepw_device_i (.clk(clk),
        .reset_n(reset_n), .dev_sel(dev_sel), .link(link), .busy(busy));
    sepw_ctl #(.SCL_HALF(16)) sepw_ctl_i (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    sepw_link_props #(.WC_CYCLES(WC)) sepw_link_props_i (.clk(clk), .reset_n(reset_n), .scl(link.scl),
        .sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .ctl_sda_oe(link.ctl_sda_oe), .busy(busy));

    always #12.5 clk = ~clk;

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] dw(input logic [2:0] s, input logic rw);
        return {`SEPW_DEV_TYPE, s, rw};
    endfunction

    // One command on the controller port; byte commands wait for the response pulse
    task automatic send(input sepw_op_t o, input logic [7:0] d, input logic nk);
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = o;
        cmd_data = d;
        cmd_nack = nk;
        @(negedge clk);
        cmd_valid = 1'b0;
        if (o == SEPW_OP_WRITE || o == SEPW_OP_READ) begin
            do begin
                @(posedge clk);
                #1;
            end while (rsp_valid !== 1'b1);
        end
    endtask

    task automatic wr_ack(input logic [7:0] d, input logic [7:0] exp);
        send(SEPW_OP_WRITE, d, 1'b0);
        chk({7'h00, rsp_ack}, exp);
    endtask

    // Write the bytes in q from address a, poll once while busy, wait for busy to fall, then poll for the ack
    task automatic ee_write(input logic [15:0] a);
        send(SEPW_OP_START, 8'h00, 1'b0);
        wr_ack(dw(dev_sel, 1'b0), 8'h01);
        wr_ack(a[15:8], 8'h01);
        wr_ack(a[7:0], 8'h01);
        for (int i = 0; i < q.size(); i++) wr_ack(q[i], 8'h01);
        send(SEPW_OP_STOP, 8'h00, 1'b0);
        send(SEPW_OP_START, 8'h00, 1'b0);
        wr_ack(dw(dev_sel, 1'b0), 8'h00);
        chk({7'h00, busy}, 8'h01);
        while (busy === 1'b1) @(negedge clk);
        send(SEPW_OP_START, 8'h00, 1'b0);
        wr_ack(dw(dev_sel, 1'b0), 8'h01);
        send(SEPW_OP_STOP, 8'h00, 1'b0);
    endtask

    // Read q.size() bytes, random from a or from the current address
    task automatic ee_read(input logic rnd, input logic [15:0] a);
        if (rnd) begin
            send(SEPW_OP_START, 8'h00, 1'b0);
            wr_ack(dw(dev_sel, 1'b0), 8'h01);
            wr_ack(a[15:8], 8'h01);
            wr_ack(a[7:0], 8'h01);
        end
        send(SEPW_OP_START, 8'h00, 1'b0);
        wr_ack(dw(dev_sel, 1'b1), 8'h01);
        for (int i = 0; i < q.size(); i++) begin
            send(SEPW_OP_READ, 8'h00, i == q.size() - 1);
            chk(rsp_data, q[i]);
        end
        send(SEPW_OP_STOP, 8'h00, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        repeat (40) @(negedge clk);
        send(SEPW_OP_START, 8'h00, 1'b0);
        wr_ack(dw(3'h2, 1'b0), 8'h00);
        send(SEPW_OP_STOP, 8'h00, 1'b0);
        $display("Test select done");
        q = '{8'ha5};
        ee_write(16'h0020);
        q = '{8'h11, 8'h22, 8'h33};
        ee_write(16'h003e);
        q = '{8'h11, 8'h22};
        ee_read(1'b1, 16'h003e);
        q = '{8'h33};
        ee_read(1'b1, 16'h0020);
        $display("Test page wrap done");
        q = '{8'h5a};
        ee_write(16'h0040);
        q = '{8'hc3};
        ee_write(16'h005f);
        q = '{8'h5a};
        ee_read(1'b0, 16'h0000);
        $display("Test write counter done");
        q = '{8'he7};
        ee_write(16'h1fff);
        q = '{8'h7e};
        ee_write(16'h0000);
        q = '{8'he7, 8'h7e};
        ee_read(1'b1, 16'h1fff);
        q = '{8'he7};
        ee_read(1'b1, 16'h1fff);
        q = '{8'h7e};
        ee_read(1'b0, 16'h0000);
        $display("Test array wrap done");
        stop_test();
    end
endmodule
